// >>> include/ccs_pkg.sv
// Constants, field layouts and carrier types for the CPU clock switch and clock output block.
package ccs_pkg;
  localparam int CCS_CLK_HZ = 40_000_000;
  localparam real CCS_STAB_MS = 31.3;
  localparam int CCS_STAB_CYCLES = int'($ceil(CCS_STAB_MS * CCS_CLK_HZ / 1000.0));
  localparam int CCS_MAIN_HZ = 4_194_304;
  localparam int CCS_SUB_HZ = 32_768;
  localparam int CCS_SWAP_CYCLES = CCS_MAIN_HZ / (4 * CCS_SUB_HZ);
  localparam int CCS_LAT_FROM_DIV64 = 1;
  localparam int CCS_LAT_FROM_DIV8 = 8;
  localparam int CCS_LAT_FROM_DIV4 = 16;
  localparam int CCS_CNT_W = 6;
  localparam int CCS_LAT_W = 6;

  localparam logic [7:0] CCS_ADDR_POWER = 8'hb3;
  localparam logic [7:0] CCS_ADDR_SYSCLK = 8'hb7;
  localparam logic [7:0] CCS_ADDR_CLKOUT1 = 8'hb8;
  localparam logic [7:0] CCS_ADDR_CLKOUT2 = 8'hb9;
  localparam logic [7:0] CCS_ADDR_PORT = 8'hba;

  localparam int CCS_SYS_SRC = 0;
  localparam int CCS_SYS_SUBDIS = 2;
  localparam int CCS_SYS_MSTOP = 3;
  localparam int CCS_PWR_DIV_LSB = 0;
  localparam int CCS_PWR_MODE_LSB = 2;
  localparam int CCS_CO1_SRC_LSB = 0;
  localparam int CCS_CO1_MASTER = 3;
  localparam int CCS_CO2_OVR = 0;
  localparam int CCS_CO2_EN_A = 1;
  localparam int CCS_CO2_EN_B = 2;
  localparam int CCS_CO2_DUTY = 3;
  localparam int CCS_PORT_LATCH_A = 0;
  localparam int CCS_PORT_LATCH_B = 1;
  localparam int CCS_PORT_DIR_A = 2;
  localparam int CCS_PORT_DIR_B = 3;

  localparam logic [3:0] CCS_RST_SYSCLK = 4'h0;
  localparam logic [3:0] CCS_RST_POWER = 4'h0;
  localparam logic [3:0] CCS_RST_CLKOUT1 = 4'h0;
  localparam logic [3:0] CCS_RST_CLKOUT2 = 4'h0;
  localparam logic [3:0] CCS_RST_PORT = 4'h0;
  localparam logic [3:0] CCS_MASK_SYSCLK = 4'hd;
  localparam logic [3:0] CCS_MASK_CLKOUT1 = 4'hb;

  typedef enum logic [1:0] {CCS_DIV64, CCS_DIV8, CCS_DIV4} ccs_div_t;

  typedef struct packed {
    logic [1:0] src;
    logic master;
    logic duty;
    logic en_a;
    logic en_b;
    logic override;
  } ccs_clkout_cfg_t;
endpackage

// >>> design/ccs_tick_div.sv
// Edge counter that divides a stream of source-clock ticks.
`timescale 1ns/1ps
`default_nettype none
module ccs_tick_div #(
  parameter int W = 6
) (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic tick, // One source-clock edge.
  input wire logic clear, // Restart the count at zero.
  output logic [W-1:0] count // Running count of ticks.
);
  logic [W-1:0] count_next;

  initial begin
    if (W < 2) begin
      $error("ccs_tick_div needs at least two bits");
    end
  end

  assign count_next = clear ? '0 : (tick ? W'(count + 1'b1) : count);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= count_next;
    end
  end
endmodule // ccs_tick_div
`default_nettype wire

// >>> design/ccs_clock_ctrl.sv
// CPU clock source and divider switch with the two-pin clock output circuit.
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ccs_clock_ctrl
  import ccs_pkg::*;
#(
  parameter int STAB_CYCLES = CCS_STAB_CYCLES,
  parameter int SWAP_CYCLES = CCS_SWAP_CYCLES
) (
  input wire logic clk, // 40 MHz system clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic main_osc_clock, // Main oscillator clock pin.
  input wire logic sub_osc_clock, // Subsystem oscillator clock pin.
  input wire logic [7:0] reg_addr, // Register address.
  input wire logic [3:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [3:0] reg_rdata, // Read data, valid the cycle after the strobe.
  output logic cpu_clk_o, // Selected CPU clock.
  output logic machine_cycle_o, // Pulse at the end of each machine cycle.
  output logic cpu_run_o, // High once the stabilisation interval is over.
  output logic switch_busy_o, // A clock switch is waiting out its latency.
  output logic main_osc_en_o, // Main oscillator runs while high.
  output logic sub_osc_en_o, // Subsystem oscillator runs while high.
  output logic [1:0] power_mode_o, // Power-down mode bits.
  output logic clock_out_pin_a_o, // Pin A output level.
  output logic clock_out_pin_a_oe, // Pin A output enable.
  output logic clock_out_pin_b_o, // Pin B output level.
  output logic clock_out_pin_b_oe // Pin B output enable.
);
  localparam int STAB_W = $clog2(STAB_CYCLES + 1);

  initial begin
    if (STAB_CYCLES < 1) begin
      $error("STAB_CYCLES must be at least one");
    end
    if (SWAP_CYCLES < 1 || SWAP_CYCLES > 63) begin
      $error("SWAP_CYCLES must lie in 1..63");
    end
  end

  logic [3:0] system_clock_mode_reg;
  logic [3:0] power_control_reg;
  logic [3:0] clock_output_source_enable_reg;
  logic [3:0] clock_output_pin_duty_reg;
  logic [3:0] port_reg;
  logic [3:0] rdata_next;
  logic [1:0] osc_s1_reg, osc_s2_reg, osc_s3_reg;
  logic app_sub_reg, app_sub_next;
  ccs_div_t app_div_reg, app_div_next;
  logic busy_reg, busy_next;
  logic [CCS_LAT_W-1:0] lat_reg, lat_next;
  logic [STAB_W-1:0] stab_reg;
  ccs_clkout_cfg_t act_reg;
  logic [CCS_CNT_W-1:0] fxx_cnt;

  // Register decode and write path.
  wire wr_sys = reg_wr && reg_addr == CCS_ADDR_SYSCLK;
  wire wr_pwr = reg_wr && reg_addr == CCS_ADDR_POWER;
  wire wr_co1 = reg_wr && reg_addr == CCS_ADDR_CLKOUT1;
  wire wr_co2 = reg_wr && reg_addr == CCS_ADDR_CLKOUT2;
  wire wr_port = reg_wr && reg_addr == CCS_ADDR_PORT;
  wire [3:0] rd_mux =
    (reg_addr == CCS_ADDR_SYSCLK) ? system_clock_mode_reg :
    (reg_addr == CCS_ADDR_POWER) ? power_control_reg :
    (reg_addr == CCS_ADDR_CLKOUT1) ? clock_output_source_enable_reg :
    (reg_addr == CCS_ADDR_CLKOUT2) ? clock_output_pin_duty_reg :
    (reg_addr == CCS_ADDR_PORT) ? port_reg : 4'h0;
  assign rdata_next = reg_rd ? rd_mux : 4'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      system_clock_mode_reg <= CCS_RST_SYSCLK;
      power_control_reg <= CCS_RST_POWER;
      clock_output_source_enable_reg <= CCS_RST_CLKOUT1;
      clock_output_pin_duty_reg <= CCS_RST_CLKOUT2;
      port_reg <= CCS_RST_PORT;
      reg_rdata <= 4'h0;
    end else begin
      if (wr_sys) system_clock_mode_reg <= reg_wdata & CCS_MASK_SYSCLK;
      if (wr_pwr) power_control_reg <= reg_wdata;
      if (wr_co1) clock_output_source_enable_reg <= reg_wdata & CCS_MASK_CLKOUT1;
      if (wr_co2) clock_output_pin_duty_reg <= reg_wdata;
      if (wr_port) port_reg <= reg_wdata;
      reg_rdata <= rdata_next;
    end
  end

  // Oscillator pins pass two flip-flops; the third stage feeds edge detection.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_s1_reg <= 2'h0;
      osc_s2_reg <= 2'h0;
      osc_s3_reg <= 2'h0;
    end else begin
      osc_s1_reg <= {sub_osc_clock, main_osc_clock};
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
    end
  end
  wire main_rise = osc_s2_reg[0] && !osc_s3_reg[0];
  wire fxt_rise = osc_s2_reg[1] && !osc_s3_reg[1];
  wire sub_level = osc_s2_reg[1];

  // Requested source and divider.
  wire req_sub = system_clock_mode_reg[CCS_SYS_SRC];
  wire [1:0] pwr_div = power_control_reg[CCS_PWR_DIV_LSB +: 2];
  ccs_div_t req_div;
  assign req_div = req_sub ? CCS_DIV4 :
                   (pwr_div == 2'h3) ? CCS_DIV4 :
                   (pwr_div == 2'h2) ? CCS_DIV8 : CCS_DIV64;

  // Selected system clock counter; its period end marks a machine cycle.
  wire fxx_tick = app_sub_reg ? fxt_rise : main_rise;
  wire period_end = (app_div_reg == CCS_DIV4) ? (fxx_cnt[1:0] == 2'h3) :
                    (app_div_reg == CCS_DIV8) ? (fxx_cnt[2:0] == 3'h7) :
                    (fxx_cnt == 6'h3f);
  wire mc_tick = fxx_tick && period_end;
  wire cpu_hi = (app_div_reg == CCS_DIV4) ? fxx_cnt[1] :
                (app_div_reg == CCS_DIV8) ? fxx_cnt[2] : fxx_cnt[5];
  wire cpu_hi75 = cpu_hi ||
                  ((app_div_reg == CCS_DIV4) ? fxx_cnt[0] :
                   (app_div_reg == CCS_DIV8) ? fxx_cnt[1] : fxx_cnt[4]);

  // Latency of a pending switch, chosen from the clock being left.
  wire switch_need = (req_sub != app_sub_reg) || (req_div != app_div_reg);
  wire swap_case = app_sub_reg || (app_div_reg == CCS_DIV4 && req_sub);
  wire [CCS_LAT_W-1:0] lat_load =
    swap_case ? CCS_LAT_W'(SWAP_CYCLES) :
    (app_div_reg == CCS_DIV4) ? CCS_LAT_W'(CCS_LAT_FROM_DIV4) :
    (app_div_reg == CCS_DIV8) ? CCS_LAT_W'(CCS_LAT_FROM_DIV8) :
    CCS_LAT_W'(CCS_LAT_FROM_DIV64);
  wire apply = busy_reg && switch_need && mc_tick && lat_reg == 1;

  // The old clock keeps running until the latency ends on a machine-cycle edge.
  always_comb begin
    busy_next = busy_reg;
    lat_next = lat_reg;
    app_sub_next = app_sub_reg;
    app_div_next = app_div_reg;
    if (!busy_reg) begin
      if (switch_need) begin
        busy_next = 1'b1;
        lat_next = lat_load;
      end
    end else if (!switch_need) begin
      busy_next = 1'b0;
    end else if (apply) begin
      busy_next = 1'b0;
      app_sub_next = req_sub;
      app_div_next = req_div;
    end else if (mc_tick) begin
      lat_next = CCS_LAT_W'(lat_reg - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      lat_reg <= '0;
      app_sub_reg <= 1'b0;
      app_div_reg <= CCS_DIV64;
    end else begin
      busy_reg <= busy_next;
      lat_reg <= lat_next;
      app_sub_reg <= app_sub_next;
      app_div_reg <= app_div_next;
    end
  end

  ccs_tick_div #(.W(CCS_CNT_W)) u_fxx_div (
    .clk(clk),
    .rst_n(rst_n),
    .tick(fxx_tick),
    .clear(apply),
    .count(fxx_cnt)
  );

  // Clock output selection; the active copy only follows when both clocks are low.
  ccs_clkout_cfg_t req_cfg;
  assign req_cfg.src = clock_output_source_enable_reg[CCS_CO1_SRC_LSB +: 2];
  assign req_cfg.master = clock_output_source_enable_reg[CCS_CO1_MASTER];
  assign req_cfg.duty = clock_output_pin_duty_reg[CCS_CO2_DUTY];
  assign req_cfg.en_a = clock_output_pin_duty_reg[CCS_CO2_EN_A];
  assign req_cfg.en_b = clock_output_pin_duty_reg[CCS_CO2_EN_B];
  assign req_cfg.override = clock_output_pin_duty_reg[CCS_CO2_OVR];

  function automatic logic co_base(ccs_clkout_cfg_t c, logic [CCS_CNT_W-1:0] n,
                                   logic c50, logic c75, logic sub);
    logic r;
    r = 1'b0;
    if (c.override) begin
      r = sub;
    end else begin
      unique case (c.src)
        2'h0: r = c.duty ? c75 : c50;
        2'h1: r = c.duty ? (n[2] | n[1]) : n[2];
        2'h2: r = c.duty ? (n[3] | n[2]) : n[3];
        2'h3: r = c.duty ? (n[5] | n[4]) : n[5];
      endcase
    end
    return r;
  endfunction

  wire cpu50 = cpu_run_o && cpu_hi;
  wire cpu75 = cpu_run_o && cpu_hi75;
  wire cur_base = co_base(act_reg, fxx_cnt, cpu50, cpu75, sub_level);
  wire new_base = co_base(req_cfg, fxx_cnt, cpu50, cpu75, sub_level);
  wire cfg_take = !cur_base && !new_base;
  wire gate_a = act_reg.master && (act_reg.override || act_reg.en_a);
  wire gate_b = act_reg.master && (act_reg.override || act_reg.en_b);
  wire pin_a_next = gate_a ? cur_base : port_reg[CCS_PORT_LATCH_A];
  wire pin_b_next = gate_b ? cur_base : port_reg[CCS_PORT_LATCH_B];
  wire main_en_next = !(system_clock_mode_reg[CCS_SYS_MSTOP] && app_sub_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_reg <= '0;
      stab_reg <= STAB_W'(STAB_CYCLES);
      cpu_run_o <= 1'b0;
      cpu_clk_o <= 1'b0;
      machine_cycle_o <= 1'b0;
      switch_busy_o <= 1'b0;
      main_osc_en_o <= 1'b1;
      sub_osc_en_o <= 1'b1;
      power_mode_o <= 2'h0;
      clock_out_pin_a_o <= 1'b0;
      clock_out_pin_a_oe <= 1'b0;
      clock_out_pin_b_o <= 1'b0;
      clock_out_pin_b_oe <= 1'b0;
    end else begin
      if (cfg_take) act_reg <= req_cfg;
      if (stab_reg != 0) stab_reg <= STAB_W'(stab_reg - 1'b1);
      cpu_run_o <= (stab_reg == 0);
      cpu_clk_o <= cpu50;
      machine_cycle_o <= mc_tick && cpu_run_o;
      switch_busy_o <= busy_reg;
      main_osc_en_o <= main_en_next;
      sub_osc_en_o <= !system_clock_mode_reg[CCS_SYS_SUBDIS];
      power_mode_o <= power_control_reg[CCS_PWR_MODE_LSB +: 2];
      clock_out_pin_a_o <= pin_a_next;
      clock_out_pin_a_oe <= port_reg[CCS_PORT_DIR_A];
      clock_out_pin_b_o <= pin_b_next;
      clock_out_pin_b_oe <= port_reg[CCS_PORT_DIR_B];
    end
  end

  // Checks.
  property p_sub_osc;
    @(posedge clk) disable iff (!rst_n)
    wr_sys ##1 1'b1 |=> sub_osc_en_o == !$past(reg_wdata[CCS_SYS_SUBDIS], 2);
  endproperty
  a_sub_osc: assert property (p_sub_osc) else $error("sub oscillator enable wrong");
  property p_run;
    @(posedge clk) disable iff (!rst_n)
    (!cpu_run_o && stab_reg == 0) |=> cpu_run_o ##1 cpu_run_o;
  endproperty
  a_run: assert property (p_run) else $error("CPU did not start after stabilisation");
  property p_lat64;
    @(posedge clk) disable iff (!rst_n)
    $rose(busy_reg) && !$past(app_sub_reg) && $past(app_div_reg) == CCS_DIV64
      && !$past(req_sub) |-> lat_reg == 6'h01;
  endproperty
  a_lat64: assert property (p_lat64) else $error("latency from divide by 64 wrong");
  property p_lat8;
    @(posedge clk) disable iff (!rst_n)
    $rose(busy_reg) && !$past(app_sub_reg) && $past(app_div_reg) == CCS_DIV8
      |-> lat_reg == 6'h08;
  endproperty
  a_lat8: assert property (p_lat8) else $error("latency from divide by 8 wrong");
  property p_lat_swap;
    @(posedge clk) disable iff (!rst_n)
    $rose(busy_reg) && $past(app_sub_reg) |-> lat_reg == CCS_LAT_W'(SWAP_CYCLES);
  endproperty
  a_lat_swap: assert property (p_lat_swap) else $error("swap latency wrong");
  property p_apply_edge;
    @(posedge clk) disable iff (!rst_n)
    ($changed(app_sub_reg) || $changed(app_div_reg)) |-> $past(mc_tick) && fxx_cnt == 6'h00;
  endproperty
  a_apply_edge: assert property (p_apply_edge) else $error("switch not on a cycle edge");
  property p_main_stop;
    @(posedge clk) disable iff (!rst_n)
    $fell(main_osc_en_o) |-> $past(app_sub_reg);
  endproperty
  a_main_stop: assert property (p_main_stop) else $error("main stopped while selected");
  property p_master;
    @(posedge clk) disable iff (!rst_n)
    !act_reg.master |=> clock_out_pin_a_o == $past(port_reg[CCS_PORT_LATCH_A])
      && clock_out_pin_b_o == $past(port_reg[CCS_PORT_LATCH_B]);
  endproperty
  a_master: assert property (p_master) else $error("clock reached pin while blocked");
  property p_override;
    @(posedge clk) disable iff (!rst_n)
    act_reg.master && act_reg.override |=> clock_out_pin_b_o == $past(sub_level)
      && clock_out_pin_a_o == $past(sub_level);
  endproperty
  a_override: assert property (p_override) else $error("override clock missing");
  property p_pin_a;
    @(posedge clk) disable iff (!rst_n)
    act_reg.master && act_reg.en_a |=> clock_out_pin_a_o == $past(cur_base);
  endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin A clock wrong");
  property p_pin_b;
    @(posedge clk) disable iff (!rst_n)
    !act_reg.en_b && !act_reg.override |=> clock_out_pin_b_o == $past(port_reg[CCS_PORT_LATCH_B]);
  endproperty
  a_pin_b: assert property (p_pin_b) else $error("pin B clocked while disabled");
  c_to_sub: cover property (@(posedge clk) disable iff (!rst_n) $rose(app_sub_reg));
  c_to_div4: cover property (@(posedge clk) disable iff (!rst_n)
    $changed(app_div_reg) && app_div_reg == CCS_DIV4);
  c_override: cover property (@(posedge clk) disable iff (!rst_n)
    act_reg.master && act_reg.override && clock_out_pin_a_o);
  c_main_off: cover property (@(posedge clk) disable iff (!rst_n) $fell(main_osc_en_o));
endmodule // ccs_clock_ctrl
`default_nettype wire

// >>> test/cpu_clock_switch_and_clock_output_test.sv
// Self-checking bench for the CPU clock switch and clock output block.
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_switch_and_clock_output_test;
  import ccs_pkg::*;
  localparam int STAB = 20;
  localparam int SWAP = 2;
  localparam int LIMIT = 60000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic main_osc_clock = 1'b0;
  logic sub_osc_clock = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [3:0] reg_wdata = 4'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_rdata;
  logic cpu_clk_o, machine_cycle_o, cpu_run_o, switch_busy_o;
  logic main_osc_en_o, sub_osc_en_o;
  logic [1:0] power_mode_o;
  logic clock_out_pin_a_o, clock_out_pin_a_oe, clock_out_pin_b_o, clock_out_pin_b_oe;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  int cpu_rises = 0;
  int mc_pulses = 0;
  logic cpu_prev = 1'b0;

  // Every machine cycle of the CPU clock holds exactly one rising edge of it.
  always @(posedge clk) begin
    cpu_prev <= cpu_clk_o;
    if (cpu_clk_o === 1'b1 && cpu_prev !== 1'b1) cpu_rises <= cpu_rises + 1;
    if (machine_cycle_o === 1'b1) mc_pulses <= mc_pulses + 1;
  end
  logic [31:0] seed = 32'h66cf;
  logic [7:0] tbl [4] = '{CCS_ADDR_CLKOUT1, CCS_ADDR_CLKOUT2, CCS_ADDR_PORT, CCS_ADDR_POWER};

  ccs_clock_ctrl #(.STAB_CYCLES(STAB), .SWAP_CYCLES(SWAP)) ccs_clock_ctrl_i (
    .clk(clk), .rst_n(rst_n), .main_osc_clock(main_osc_clock),
    .sub_osc_clock(sub_osc_clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_clk_o(cpu_clk_o),
    .machine_cycle_o(machine_cycle_o), .cpu_run_o(cpu_run_o),
    .switch_busy_o(switch_busy_o), .main_osc_en_o(main_osc_en_o),
    .sub_osc_en_o(sub_osc_en_o), .power_mode_o(power_mode_o),
    .clock_out_pin_a_o(clock_out_pin_a_o), .clock_out_pin_a_oe(clock_out_pin_a_oe),
    .clock_out_pin_b_o(clock_out_pin_b_o), .clock_out_pin_b_oe(clock_out_pin_b_oe));

  always #12.5 clk = ~clk;
  // A stopped oscillator stands still instead of running on.
  always #100 if (main_osc_en_o === 1'b1) main_osc_clock = ~main_osc_clock;
  always #250 if (sub_osc_en_o === 1'b1) sub_osc_clock = ~sub_osc_clock;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      report_and_stop();
    end
  end

  task chk(input string nm, input logic [7:0] e, input logic [7:0] got);
    total_checks++;
    if (got !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, got);
    end
  endtask

  task chk_rng(input string nm, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("unexpected %s: expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  task wr(input logic [7:0] a, input logic [3:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task rdchk(input logic [7:0] a, input logic [3:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", {4'h0, e}, {4'h0, reg_rdata});
  endtask

  task settle;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Counts machine-cycle pulses seen while a switch is pending; -1 if none starts.
  task sw_count(output int n);
    int i;
    i = 0;
    n = 0;
    do begin @(posedge clk); #1; i++; end while (switch_busy_o !== 1'b1 && i < 8);
    if (switch_busy_o !== 1'b1) n = -1;
    while (switch_busy_o === 1'b1 && i < 8000) begin
      if (machine_cycle_o === 1'b1) n++;
      @(posedge clk);
      #1;
      i++;
    end
  endtask

  // Distance in system clocks between two machine-cycle pulses.
  task mc_gap(output int g);
    int i;
    i = 0;
    g = 0;
    do begin @(posedge clk); #1; i++; end while (machine_cycle_o !== 1'b1 && i < 4000);
    do begin @(posedge clk); #1; g++; end while (machine_cycle_o !== 1'b1 && g < 4000);
  endtask

  task pins(input int len, output int ra, output int ha, output int rb);
    logic pa, pb;
    int k;
    ra = 0;
    ha = 0;
    rb = 0;
    #1;
    pa = clock_out_pin_a_o;
    pb = clock_out_pin_b_o;
    for (k = 0; k < len; k++) begin
      @(posedge clk);
      #1;
      if (clock_out_pin_a_o === 1'b1 && pa !== 1'b1) ra++;
      if (clock_out_pin_a_o === 1'b1) ha++;
      if (clock_out_pin_b_o === 1'b1 && pb !== 1'b1) rb++;
      pa = clock_out_pin_a_o;
      pb = clock_out_pin_b_o;
    end
  endtask

  int n, ra, ha, rb, k;
  logic [7:0] a;
  logic [3:0] d;
  int exp_r [4] = '{2, 16, 8, 2};

  initial begin
    repeat (6) @(posedge clk);
    chk("main_osc_en", 8'h1, {7'h0, main_osc_en_o});
    chk("sub_osc_en", 8'h1, {7'h0, sub_osc_en_o});
    rst_n <= 1'b1;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (cpu_run_o !== 1'b1 && n < 100);
    chk_rng("run_delay", STAB, STAB + 2, n);
    mc_gap(n);
    chk_rng("gap_div64", 511, 513, n);
    for (k = 0; k < 4; k++) rdchk(tbl[k], 4'h0);
    rdchk(CCS_ADDR_SYSCLK, 4'h0);
    wr(8'hc5, 4'hf);
    rdchk(8'hc5, 4'h0);
    wr(CCS_ADDR_CLKOUT1, 4'hf);
    rdchk(CCS_ADDR_CLKOUT1, 4'hb);
    for (k = 0; k < 12; k++) begin
      seed = lfsr(seed);
      a = tbl[seed[1:0]];
      d = seed[7:4];
      if (a == CCS_ADDR_POWER) d = {seed[7:6], 2'b00};
      wr(a, d);
      rdchk(a, (a == CCS_ADDR_CLKOUT1) ? (d & CCS_MASK_CLKOUT1) : d);
      if (a == CCS_ADDR_POWER) chk("power_mode", {6'h0, d[3:2]}, {6'h0, power_mode_o});
    end
    for (k = 0; k < 4; k++) wr(tbl[k], 4'h0);
    wr(CCS_ADDR_SYSCLK, 4'h4);
    settle();
    chk("sub_osc_en", 8'h0, {7'h0, sub_osc_en_o});
    wr(CCS_ADDR_SYSCLK, 4'h8);
    settle();
    chk("main_osc_en", 8'h1, {7'h0, main_osc_en_o});
    wr(CCS_ADDR_SYSCLK, 4'h0);
    settle();
    chk("sub_osc_en", 8'h1, {7'h0, sub_osc_en_o});
    // Start-up order: master off, source, latch, direction, duty, enables, master.
    wr(CCS_ADDR_CLKOUT1, 4'h1);
    wr(CCS_ADDR_PORT, 4'hd);
    wr(CCS_ADDR_CLKOUT2, 4'h6);
    pins(600, ra, ha, rb);
    chk("pin_a_latch", 8'h1, {7'h0, clock_out_pin_a_o});
    chk("pin_b_latch", 8'h0, {7'h0, clock_out_pin_b_o});
    chk("pin_oe", 8'h3, {6'h0, clock_out_pin_a_oe, clock_out_pin_b_oe});
    chk_rng("edges_off", 0, 0, ra + rb);
    wr(CCS_ADDR_PORT, 4'hc);
    for (k = 0; k < 4; k++) begin
      wr(CCS_ADDR_CLKOUT1, 4'h8 | k[3:0]);
      pins(1024, ra, ha, rb);
      chk_rng("edges_a", exp_r[k] - 1, exp_r[k] + 1, ra);
      chk_rng("edges_b", exp_r[k] - 1, exp_r[k] + 1, rb);
    end
    wr(CCS_ADDR_CLKOUT1, 4'h9);
    wr(CCS_ADDR_CLKOUT2, 4'h2);
    pins(1024, ra, ha, rb);
    chk_rng("a_only_b", 0, 0, rb);
    chk_rng("high_50", 480, 544, ha);
    wr(CCS_ADDR_CLKOUT2, 4'ha);
    pins(1024, ra, ha, rb);
    chk_rng("high_75", 736, 800, ha);
    wr(CCS_ADDR_CLKOUT2, 4'h4);
    pins(1024, ra, ha, rb);
    chk_rng("b_only_a", 0, 0, ra);
    chk_rng("b_only_b", 15, 17, rb);
    wr(CCS_ADDR_CLKOUT2, 4'h1);
    pins(1024, ra, ha, rb);
    chk_rng("ovr_a", 49, 53, ra);
    chk_rng("ovr_b", 49, 53, rb);
    chk_rng("ovr_high", 470, 554, ha);
    wr(CCS_ADDR_CLKOUT1, 4'h1);
    pins(600, ra, ha, rb);
    chk_rng("ovr_off", 0, 0, ra + rb);
    wr(CCS_ADDR_CLKOUT2, 4'h0);
    // The bench raises no interrupt, so nothing breaks into a switch.
    wr(CCS_ADDR_POWER, 4'h3);
    sw_count(n);
    chk_rng("lat_div64", 0, 2, n);
    mc_gap(n);
    chk_rng("gap_div4", 31, 33, n);
    wr(CCS_ADDR_POWER, 4'h2);
    sw_count(n);
    chk_rng("lat_div4", 15, 17, n);
    mc_gap(n);
    chk_rng("gap_div8", 63, 65, n);
    wr(CCS_ADDR_POWER, 4'h3);
    sw_count(n);
    chk_rng("lat_div8", 7, 9, n);
    wr(CCS_ADDR_SYSCLK, 4'h1);
    sw_count(n);
    chk_rng("lat_swap", SWAP - 1, SWAP + 1, n);
    mc_gap(n);
    chk_rng("gap_sub", 79, 81, n);
    chk("main_osc_en", 8'h1, {7'h0, main_osc_en_o});
    wr(CCS_ADDR_SYSCLK, 4'h9);
    settle();
    chk("main_osc_en", 8'h0, {7'h0, main_osc_en_o});
    rdchk(CCS_ADDR_SYSCLK, 4'h9);
    wr(CCS_ADDR_SYSCLK, 4'h1);
    settle();
    chk("main_osc_en", 8'h1, {7'h0, main_osc_en_o});
    repeat (200) @(posedge clk);
    wr(CCS_ADDR_SYSCLK, 4'h0);
    sw_count(n);
    chk_rng("lat_back", SWAP - 1, SWAP + 1, n);
    mc_gap(n);
    chk_rng("gap_back", 31, 33, n);
    wr(CCS_ADDR_POWER, 4'h0);
    sw_count(n);
    chk_rng("lat_to64", 15, 17, n);
    mc_gap(n);
    chk_rng("gap_to64", 511, 513, n);
    wr(CCS_ADDR_POWER, 4'h1);
    sw_count(n);
    chk_rng("code01_switch", -1, -1, n);
    chk_rng("cpu_clk_rises", mc_pulses - 1, mc_pulses + 1, cpu_rises);
    report_and_stop();
  end
endmodule // cpu_clock_switch_and_clock_output_test
`default_nettype wire
